// ### hw/dpsc_pkg.sv
// Package: constants and types of the dual wiper serial control block
package dpsc_pkg;
  // ---------------------------------------------------------------
  // Word layout
  // ---------------------------------------------------------------
  localparam int WORD_W = 24;
  localparam int CMD_MSB = 23;
  localparam int CMD_LSB = 20;
  localparam int ADR_MSB = 19;
  localparam int ADR_LSB = 16;
  localparam int DAT_MSB = 15;
  localparam int WIP_W = 10;
  localparam int NV_DEPTH = 16;
  localparam logic [9:0] WIP_MID = 10'h200;
  localparam logic [9:0] WIP_MAX = 10'h3ff;
  localparam logic [9:0] WIP_MIN = 10'h000;
  localparam logic [3:0] ADR_WIP_ONE = 4'h0;
  localparam logic [3:0] ADR_WIP_TWO = 4'h1;
  localparam logic [3:0] ADR_RESERVED = 4'hf;
  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_RESTORE = 4'h1;
  localparam logic [3:0] CMD_STORE = 4'h2;
  localparam logic [3:0] CMD_STORE_USER = 4'h3;
  localparam logic [3:0] CMD_DEC6_ONE = 4'h4;
  localparam logic [3:0] CMD_DEC1_ALL = 4'h7;
  localparam logic [3:0] CMD_RELOAD_ALL = 4'h8;
  localparam logic [3:0] CMD_READ_NV = 4'h9;
  localparam logic [3:0] CMD_READ_WIP = 4'ha;
  localparam logic [3:0] CMD_WRITE = 4'hb;
  localparam logic [3:0] CMD_INC6_ONE = 4'hc;
  localparam logic [3:0] CMD_INC1_ALL = 4'hf;
  // ---------------------------------------------------------------
  // Synchroniser bit positions
  // ---------------------------------------------------------------
  localparam int P_SCLK = 0;
  localparam int P_CS = 1;
  localparam int P_SDI = 2;
  localparam int P_WP = 3;
  localparam int P_PR = 4;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int STORE_TIME_NS = 25000000;
  localparam int RELOAD_TIME_NS = 1000000;
  localparam int READ_TIME_NS = 100000;
  localparam int PRESET_TIME_NS = 140000;
  localparam int STORE_CYC = STORE_TIME_NS / CLK_PERIOD_NS;
  localparam int RELOAD_CYC = RELOAD_TIME_NS / CLK_PERIOD_NS;
  localparam int READ_CYC = READ_TIME_NS / CLK_PERIOD_NS;
  localparam int PRESET_CYC = PRESET_TIME_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 23;

  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_BUSY = 1'b1} dpsc_state_t;

  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] d;
    dpsc_state_t st;
    logic [WORD_W-1:0] sr;
    logic [CNT_W-1:0] cnt;
    logic [WIP_W-1:0] wip0;
    logic [WIP_W-1:0] wip1;
    logic [NV_DEPTH-1:0][15:0] nv;
    logic sdo;
    logic sdo_oe;
    logic rdy;
  } dpsc_reg_t;
endpackage

// ### hw/dpsc_top.sv
// Serial control of a dual nonvolatile wiper: shifter, commands, preset
// Summary of operation
// - Each rising serial clock edge while chip select is low and no slow operation runs captures one input bit.
// - Words arrive MSB first and the first bit captured is the MSB.
// - Read commands return nonvolatile or wiper data on SDO in the next word.
// - Other commands shift the received word out on SDO 24 clocks later.
// - Address zero selects wiper one and address one selects wiper two.
// - Write protect low blocks every change except preset, restore and reload-all.
// - Restore and reload-all still reload wipers while write protected.
// - A preset strobe reloads both wipers from nonvolatile storage.
// - Wiper storage holds midscale 512 until the user stores another value.
// - The preset reload happens on the rising edge of the preset input.
// - Chip select is low while shifting and the command runs when it rises.
// - Ready returns high when stores, reload-all, reads or a preset finish.
// - A word is 4 command bits, 4 address bits and 16 data bits.
// - The falling edge of preset sets both wipers to midscale; later commands can still change them while it is low.
// - The shifter is locked while a slow operation is in progress.
`timescale 1ns/100ps
module dpsc_top
  import dpsc_pkg::*;
#(
  parameter int STORE_CYCLES = dpsc_pkg::STORE_CYC,
  parameter int RELOAD_CYCLES = dpsc_pkg::RELOAD_CYC,
  parameter int READ_CYCLES = dpsc_pkg::READ_CYC,
  parameter int PRESET_CYCLES = dpsc_pkg::PRESET_CYC
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  input wire logic write_protect_n,
  input wire logic preset_strobe_n,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  output logic ready,
  output logic [dpsc_pkg::WIP_W-1:0] wiper_register_one,
  output logic [dpsc_pkg::WIP_W-1:0] wiper_register_two
);
  import dpsc_pkg::*;

  // ---------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------
  localparam int CNT_MAX = (1 << CNT_W) - 1;
  if (STORE_CYCLES < 1 || STORE_CYCLES > CNT_MAX ||
      RELOAD_CYCLES < 1 || RELOAD_CYCLES > CNT_MAX ||
      READ_CYCLES < 1 || READ_CYCLES > CNT_MAX ||
      PRESET_CYCLES < 1 || PRESET_CYCLES > CNT_MAX)
  begin : g_bad_cycles
    $error("dpsc_top: busy cycle count out of range");
  end

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_m_b;
  logic rst_s_b;
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_m_b <= 1'b0;
      rst_s_b <= 1'b0;
    end
    else
    begin
      rst_m_b <= 1'b1;
      rst_s_b <= rst_m_b;
    end
  end

  // ---------------------------------------------------------------
  // Wiper adjust
  // ---------------------------------------------------------------
  function automatic logic [WIP_W-1:0] dpsc_adj(
    input logic [WIP_W-1:0] v,
    input logic [3:0] c
  );
    logic [WIP_W-1:0] res;
    res = v;
    unique case ({c[3], c[1]})
      2'b00: res = v >> 1;
      2'b01: res = (v == WIP_MIN) ? WIP_MIN : v - 10'h001;
      2'b10: res = v[WIP_W-1] ? WIP_MAX : v << 1;
      2'b11: res = (v == WIP_MAX) ? WIP_MAX : v + 10'h001;
    endcase
    return res;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  localparam dpsc_reg_t RST_VAL = '{
    s1: 5'h1e, s2: 5'h1e, d: 5'h1e, st: ST_IDLE,
    sr: 24'h000000, cnt: 23'h000000, wip0: WIP_MID, wip1: WIP_MID,
    nv: {{(NV_DEPTH-2){16'h0000}}, {6'h00, WIP_MID}, {6'h00, WIP_MID}},
    sdo: 1'b1, sdo_oe: 1'b0, rdy: 1'b1
  };

  dpsc_reg_t r;
  dpsc_reg_t n;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic cs_fall;
  logic pr_fall;
  logic pr_rise;
  logic wp_ok;
  logic [3:0] cmd;
  logic [3:0] adr;
  logic [15:0] dat;

  assign sclk_rise = r.s2[P_SCLK] & ~r.d[P_SCLK];
  assign sclk_fall = ~r.s2[P_SCLK] & r.d[P_SCLK];
  assign cs_rise = r.s2[P_CS] & ~r.d[P_CS];
  assign cs_fall = ~r.s2[P_CS] & r.d[P_CS];
  assign pr_fall = ~r.s2[P_PR] & r.d[P_PR];
  assign pr_rise = r.s2[P_PR] & ~r.d[P_PR];
  assign wp_ok = r.s2[P_WP];
  assign cmd = r.sr[CMD_MSB:CMD_LSB];
  assign adr = r.sr[ADR_MSB:ADR_LSB];
  assign dat = r.sr[DAT_MSB:0];

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    n = r;
    n.s1 = {preset_strobe_n, write_protect_n, spi_sdi, spi_cs_n, spi_sclk};
    n.s2 = r.s1;
    n.d = r.s2;
    n.sdo_oe = ~r.s2[P_CS];
    if (r.st == ST_BUSY)
    begin
      if (r.cnt == '0)
      begin
        n.st = ST_IDLE;
        n.rdy = 1'b1;
      end
      else
      begin
        n.cnt = r.cnt - 23'h000001;
      end
    end
    if ((cs_fall || (sclk_fall && !r.s2[P_CS])))
    begin
      n.sdo = r.sr[WORD_W-1];
    end
    if (r.st == ST_IDLE && !r.s2[P_CS] && sclk_rise)
    begin
      n.sr = {r.sr[WORD_W-2:0], r.s2[P_SDI]};
    end
    if (r.st == ST_IDLE && cs_rise)
    begin
      unique case (cmd)
        CMD_NOP: ;
        CMD_RESTORE:
        begin
          if (adr == ADR_WIP_ONE)
            n.wip0 = r.nv[ADR_WIP_ONE][WIP_W-1:0];
          else if (adr == ADR_WIP_TWO)
            n.wip1 = r.nv[ADR_WIP_TWO][WIP_W-1:0];
        end
        CMD_STORE, CMD_STORE_USER:
        begin
          if (wp_ok)
          begin
            if (adr == ADR_WIP_ONE)
              n.nv[ADR_WIP_ONE] = {6'h00, r.wip0};
            else if (adr == ADR_WIP_TWO)
              n.nv[ADR_WIP_TWO] = {6'h00, r.wip1};
            else if (cmd == CMD_STORE_USER && adr != ADR_RESERVED)
              n.nv[adr] = dat;
            n.st = ST_BUSY;
            n.cnt = CNT_W'(STORE_CYCLES - 1);
            n.rdy = 1'b0;
          end
        end
        CMD_RELOAD_ALL:
        begin
          n.wip0 = r.nv[ADR_WIP_ONE][WIP_W-1:0];
          n.wip1 = r.nv[ADR_WIP_TWO][WIP_W-1:0];
          n.st = ST_BUSY;
          n.cnt = CNT_W'(RELOAD_CYCLES - 1);
          n.rdy = 1'b0;
        end
        CMD_READ_NV, CMD_READ_WIP:
        begin
          if (cmd == CMD_READ_NV)
            n.sr = {cmd, adr, r.nv[adr]};
          else
            n.sr = {cmd, adr, 6'h00, adr[0] ? r.wip1 : r.wip0};
          n.st = ST_BUSY;
          n.cnt = CNT_W'(READ_CYCLES - 1);
          n.rdy = 1'b0;
        end
        CMD_WRITE:
        begin
          if (wp_ok && adr == ADR_WIP_ONE)
            n.wip0 = dat[WIP_W-1:0];
          else if (wp_ok && adr == ADR_WIP_TWO)
            n.wip1 = dat[WIP_W-1:0];
        end
        default: // adjust commands
        begin
          if (wp_ok)
          begin
            if (cmd[0] || adr == ADR_WIP_ONE)
              n.wip0 = dpsc_adj(r.wip0, cmd);
            if (cmd[0] || adr == ADR_WIP_TWO)
              n.wip1 = dpsc_adj(r.wip1, cmd);
          end
        end
      endcase
    end
    if (pr_fall)
    begin
      n.wip0 = WIP_MID;
      n.wip1 = WIP_MID;
    end
    else if (pr_rise)
    begin
      n.wip0 = r.nv[ADR_WIP_ONE][WIP_W-1:0];
      n.wip1 = r.nv[ADR_WIP_TWO][WIP_W-1:0];
      n.st = ST_BUSY;
      n.cnt = CNT_W'(PRESET_CYCLES - 1);
      n.rdy = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_s_b)
  begin
    if (!rst_s_b)
      r <= RST_VAL;
    else
      r <= n;
  end

  assign spi_sdo = r.sdo;
  assign spi_sdo_oe = r.sdo_oe;
  assign ready = r.rdy;
  assign wiper_register_one = r.wip0;
  assign wiper_register_two = r.wip1;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_s_b);

  a_bit_capture: assert property (
    r.st == ST_IDLE && !r.s2[P_CS] && sclk_rise && !cs_rise
    |=> r.sr[0] == $past(r.s2[P_SDI]) && r.sr[23:1] == $past(r.sr[22:0]))
    else $error("serial bit not captured");
  a_msb_order: assert property (
    r.st == ST_IDLE && !r.s2[P_CS] && sclk_rise
    |=> r.sr[WORD_W-1] == $past(r.sr[WORD_W-2]))
    else $error("shift direction wrong");
  a_read_load: assert property (
    r.st == ST_IDLE && cs_rise && cmd == CMD_READ_NV
    |=> r.sr[15:0] == $past(r.nv[adr]) && !r.rdy)
    else $error("readback not loaded");
  a_chain_out: assert property (
    sclk_fall && !r.s2[P_CS] |=> spi_sdo == $past(r.sr[WORD_W-1]))
    else $error("daisy chain bit wrong");
  a_write_sel: assert property (
    r.st == ST_IDLE && cs_rise && cmd == CMD_WRITE && wp_ok &&
    adr == ADR_WIP_TWO && !pr_fall && !pr_rise
    |=> wiper_register_two == $past(dat[9:0]) &&
        $stable(wiper_register_one))
    else $error("wrong wiper selected");
  a_protect_hold: assert property (
    r.st == ST_IDLE && cs_rise && !wp_ok && cmd == CMD_WRITE &&
    !pr_fall && !pr_rise
    |=> $stable(wiper_register_one) && $stable(wiper_register_two))
    else $error("write protect ignored");
  a_reload_wp: assert property (
    r.st == ST_IDLE && cs_rise && cmd == CMD_RELOAD_ALL && !pr_fall
    |=> wiper_register_one == r.nv[ADR_WIP_ONE][9:0] &&
        wiper_register_two == r.nv[ADR_WIP_TWO][9:0])
    else $error("reload all failed");
  a_preset_load: assert property (
    pr_rise |=> wiper_register_one == r.nv[ADR_WIP_ONE][9:0] && !ready)
    else $error("preset reload missing");
  a_preset_mid: assert property (
    pr_fall |=> wiper_register_one == WIP_MID &&
                wiper_register_two == WIP_MID)
    else $error("preset midscale missing");
  a_ready_done: assert property (
    r.st == ST_BUSY && r.cnt == '0 && !pr_rise && !cs_rise
    |=> ready ##1 ready)
    else $error("ready not restored");
  a_shift_lock: assert property (
    r.st == ST_BUSY && !pr_rise |=> $stable(r.sr))
    else $error("shifter not locked");

  c_store: cover property (cs_rise && cmd == CMD_STORE && wp_ok);
  c_read_wip: cover property (cs_rise && cmd == CMD_READ_WIP ##1 !ready);
  c_preset: cover property (pr_fall ##[1:100] pr_rise);
  c_blocked: cover property (cs_rise && !wp_ok && cmd == CMD_WRITE);
endmodule

// ### tb/dpsc_host.sv
// Host side model: clocks one framed word out and captures the reply
`timescale 1ns/100ps
module dpsc_host
  import dpsc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [31:0] word,
  input wire logic [5:0] nbits,
  input wire logic sdo,
  input wire logic sdo_oe,
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  output logic done,
  output logic [31:0] rx
);
  // -------------------------------------------------------------
  // Frame engine, 64 ns serial clock
  // -------------------------------------------------------------
  logic sdo_w;
  int i;
  assign sdo_w = sdo_oe ? sdo : 1'b1;
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
    done = 1'b1;
    rx = '0;
    forever
    begin
      @(posedge sys_clk);
      if (go === 1'b1)
      begin
        done <= 1'b0;
        cs_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        for (i = nbits - 1; i >= 0; i--)
        begin
          sdi <= word[i];
          repeat (4) @(posedge sys_clk);
          sclk <= 1'b1;
          rx <= {rx[30:0], sdo_w};
          repeat (4) @(posedge sys_clk);
          sclk <= 1'b0;
        end
        repeat (4) @(posedge sys_clk);
        cs_n <= 1'b1;
        sdi <= ~sdi;
        repeat (8) @(posedge sys_clk);
        done <= 1'b1;
      end
    end
  end
endmodule

// ### tb/dual_pot_serial_control_tb_top.sv
// Testbench of the dual wiper serial control block
`timescale 1ns/100ps
module dual_pot_serial_control_tb_top;
  import dpsc_pkg::*;
  typedef struct packed {
    logic [23:0] word;
    logic wp;
    logic [9:0] e1;
    logic [9:0] e2;
  } dpsc_row_t;
  localparam int RD_CYC = 5;
  localparam int PR_CYC = 8;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic wp_n = 1'b1;
  logic pr_n = 1'b1;
  logic go = 1'b0;
  logic [31:0] word = '0;
  logic [5:0] nbits = 6'h18;
  logic sclk, cs_n, sdi, sdo, sdo_oe, ready, done;
  logic [9:0] w1, w2;
  logic [31:0] rx;
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  int low_cnt = 0;
  int r;
  dpsc_row_t rows [18] = '{
    '{24'hb00100, 1'b1, 10'h100, 10'h200},
    '{24'hb10155, 1'b1, 10'h100, 10'h155},
    '{24'h200000, 1'b1, 10'h100, 10'h155},
    '{24'h800000, 1'b1, 10'h100, 10'h200},
    '{24'hb00300, 1'b1, 10'h300, 10'h200},
    '{24'hb00055, 1'b0, 10'h300, 10'h200},
    '{24'h100000, 1'b0, 10'h100, 10'h200},
    '{24'h000000, 1'b0, 10'h100, 10'h200},
    '{24'hf00000, 1'b1, 10'h101, 10'h201},
    '{24'h700000, 1'b1, 10'h100, 10'h200},
    '{24'hc00000, 1'b1, 10'h200, 10'h200},
    '{24'h500000, 1'b1, 10'h100, 10'h100},
    '{24'he10000, 1'b1, 10'h100, 10'h101},
    '{24'h610000, 1'b1, 10'h100, 10'h100},
    '{24'hd00000, 1'b1, 10'h200, 10'h200},
    '{24'h400000, 1'b1, 10'h100, 10'h200},
    '{24'h300000, 1'b1, 10'h100, 10'h200},
    '{24'h320abc, 1'b1, 10'h100, 10'h200}};
  // -------------------------------------------------------------
  // Clock, instances, watchdog
  // -------------------------------------------------------------
  initial
  begin
    forever #4 sys_clk = ~sys_clk;
  end
  dpsc_top #(.STORE_CYCLES(400), .RELOAD_CYCLES(10), .READ_CYCLES(RD_CYC),
    .PRESET_CYCLES(PR_CYC)) dpsc_top_inst (.sys_clk(sys_clk), .rst_b(rst_b),
    .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_sdi(sdi),
    .write_protect_n(wp_n), .preset_strobe_n(pr_n), .spi_sdo(sdo),
    .spi_sdo_oe(sdo_oe), .ready(ready), .wiper_register_one(w1),
    .wiper_register_two(w2));
  dpsc_host dpsc_host_inst (.sys_clk(sys_clk), .go(go), .word(word),
    .nbits(nbits), .sdo(sdo), .sdo_oe(sdo_oe), .sclk(sclk), .cs_n(cs_n),
    .sdi(sdi), .done(done), .rx(rx));
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (ready === 1'b0)
      low_cnt <= low_cnt + 1;
    if (cyc == 30000)
    begin
      errors++;
      finish_test();
    end
  end
  // -------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [31:0] w, input logic [5:0] n,
    input bit rdy);
    int k;
    word <= w;
    nbits <= n;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (done !== 1'b1 && k < 2000);
    while (rdy && ready !== 1'b1 && k < 4000)
    begin
      @(posedge sys_clk);
      k++;
    end
  endtask
  // -------------------------------------------------------------
  // Sequence
  // -------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk({w1, w2}, {10'h200, 10'h200});
    $display("power-up test done");
    for (r = 0; r < 18; r++)
    begin
      wp_n <= rows[r].wp;
      send({8'h00, rows[r].word}, 6'h18, 1'b1);
      chk({w1, w2}, {rows[r].e1, rows[r].e2});
    end
    $display("table test done");
    send(32'h00b00123, 6'h18, 1'b1);
    send(32'h0, 6'h18, 1'b1);
    chk(rx[23:0], 24'hb00123);
    low_cnt = 0;
    send(32'h00900000, 6'h18, 1'b1);
    chk(low_cnt, RD_CYC);
    send(32'h00920000, 6'h18, 1'b1);
    chk(rx[23:0], 24'h900100);
    send(32'h00a10000, 6'h18, 1'b1);
    chk(rx[23:0], 24'h920abc);
    send(32'h0, 6'h18, 1'b1);
    chk(rx[23:0], 24'ha10200);
    $display("readback test done");
    send(32'h00200000, 6'h18, 1'b0);
    send(32'h00b00111, 6'h18, 1'b1);
    chk(w1, 10'h123);
    send(32'h05b10077, 6'h1c, 1'b1);
    chk(w2, 10'h077);
    $display("lock and framing test done");
    pr_n <= 1'b0;
    repeat (12) @(posedge sys_clk);
    chk({w1, w2}, {10'h200, 10'h200});
    repeat (20) @(posedge sys_clk);
    chk(w1, 10'h200);
    low_cnt = 0;
    pr_n <= 1'b1;
    repeat (30) @(posedge sys_clk);
    chk({w1, w2}, {10'h123, 10'h200});
    chk(low_cnt, PR_CYC);
    $display("preset test done");
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk({w1, w2, ready, sdo_oe}, {10'h200, 10'h200, 2'b10});
    send(32'h00b10321, 6'h18, 1'b1);
    chk(w2, 10'h321);
    $display("reset test done");
    finish_test();
  end
endmodule
